// [pkg/mem_policy_params.svh]
// Purpose: Offsets, field positions and reset values of the memory policy unit.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef MEM_POLICY_PARAMS_SVH
`define MEM_POLICY_PARAMS_SVH

`define MP_CTRL_OFFSET      12'h000
`define MP_ACTIVE_OFFSET    12'h004
`define MP_STATUS_OFFSET    12'h008

`define MP_CTRL_UNALIGN_BIT 0
`define MP_CTRL_DC_BIT      1
`define MP_CTRL_IC_BIT      2
`define MP_CTRL_DFAULT_BIT  3
`define MP_CTRL_SPERR_BIT   4
`define MP_CTRL_WIDTH       5

`define MP_ACTIVE_DC_BIT    0
`define MP_ACTIVE_IC_BIT    1
`define MP_ACTIVE_WIDTH     2

`define MP_STATUS_CLASS_LSB 0
`define MP_STATUS_CLASS_MSB 2
`define MP_STATUS_SYNC_BIT  3
`define MP_STATUS_CPMISS_BIT 4
`define MP_STATUS_RAZ_BIT   5

`define MP_CTRL_RESET       5'h00
`define MP_ACTIVE_RESET     2'h0
`define MP_STATUS_RESET     6'h00

`endif

// [pkg/mem_policy_pkg.sv]
// Purpose: Types shared by the memory policy unit.
// Assumes: Nothing beyond the parameter header.
// Notes:   Fault class codes are fixed binary values.
package mem_policy_pkg;

  typedef enum logic [2:0] {
    fault_none_type      = 3'b000,
    fault_memmanage_type = 3'b001,
    fault_bus_type       = 3'b010,
    fault_secure_type    = 3'b011,
    fault_usage_type     = 3'b100
  } fault_class_type;

endpackage

// [design/mem_policy.sv]
// Purpose: Sorts memory faults into classes, sets bus fault timing and decides cache,
//          exclusive and merge attributes for one access per cycle.
// Assumes: All access inputs come from logic on pclk; APB slave with zero wait states.
// Notes:   Decisions are registered and appear one cycle after the access is presented.
// Contract
// [RL1] Poisoned AXI read data raises a bus fault.
// [RL2] Peripheral AHB error equals AXI slave error.
// [RL3] Gate-rejected load or store: synchronous bus fault.
// [RL4] Gate-rejected slave port access gets error response.
// [RL5] Slave port write abort only from memory errors.
// [RL6] Fetches, loads, listed stores, ECC: synchronous.
// [RL7] Other stores, dirty linefills, eviction ECC: asynchronous.
// [RL8] Blocked debugger access: error, no secure fault.
// [RL9] Debug protection bit follows security attribution.
// [RL10] Trap bit or unsupported instruction: unaligned fault.
// [RL11] Unaligned Device access raises unaligned fault.
// [RL12] Vector element misalignment raises unaligned fault.
// [RL13] Missing coprocessor raises the coprocessor fault.
// [RL14] Allocate only for Normal cacheable regions.
// [RL15] Data: shareable uncached; needs enable and active.
// [RL16] Fetches cached regardless of shareability when enabled.
// [RL17] Unified cache: code region reads, data bits.
// [RL18] Store hitting unified line invalidates it.
// [RL19] Only shareable exclusives marked exclusive on bus.
// [RL20] Shared exclusives use internal and external monitor.
// [RL21] Merge Normal accesses, never Device ones; the code still merges Device accesses of vector micro-ops.
// [RL22] Interconnect must not merge Device accesses.
// [RL23] Vector micro-op may merge Device accesses.
// [RL24] Gate-failed read, faults disabled: zero, writes ignored.
// [RL25] One fault class plus a synchronous flag.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "mem_policy_params.svh"

module mem_policy (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             acc_valid,
  input  wire logic                             acc_fetch,
  input  wire logic                             acc_store,
  input  wire logic                             acc_vector,
  input  wire logic                             acc_stacking,
  input  wire logic                             acc_exclusive,
  input  wire logic                             acc_unaligned,
  input  wire logic                             acc_elem_misaligned,
  input  wire logic                             acc_no_unaligned_instr,
  input  wire logic                             acc_device,
  input  wire logic                             acc_normal_cacheable,
  input  wire logic                             acc_shareable,
  input  wire logic                             acc_code_region,
  input  wire logic                             acc_priv_periph,
  input  wire logic                             acc_priv_violation,
  input  wire logic                             acc_merge_req,
  input  wire logic                             acc_ucache_hit,
  input  wire logic                             gate_reject,
  input  wire logic                             protection_fault,
  input  wire logic                             attribution_fault,
  input  wire logic                             coproc_access,
  input  wire logic                             coproc_present,
  input  wire logic                             axi_slave_error,
  input  wire logic                             axi_decode_error,
  input  wire logic                             axi_read_poison,
  input  wire logic                             main_ahb_error,
  input  wire logic                             periph_ahb_error,
  input  wire logic                             periph_apb_error,
  input  wire logic                             ecc_uncorrectable,
  input  wire logic                             ecc_in_eviction,
  input  wire logic                             dirty_linefill_error,
  input  wire logic                             slave_port_valid,
  input  wire logic                             slave_port_write,
  input  wire logic                             slave_port_gate_reject,
  input  wire logic                             instr_local_mem_error_in,
  input  wire logic                             data_local_mem_error_in,
  input  wire logic                             debug_valid,
  input  wire logic                             debug_attr_blocked,
  input  wire logic                             debug_attr_nonsecure,
  output mem_policy_pkg::fault_class_type       fault_class,
  output logic                                  fault_valid,
  output logic                                  fault_sync,
  output logic                                  fault_cpmiss,
  output logic                                  read_as_zero,
  output logic                                  write_ignore,
  output logic                                  dcache_allocate,
  output logic                                  icache_allocate,
  output logic                                  ucache_allocate,
  output logic                                  ucache_invalidate,
  output logic                                  bus_exclusive,
  output logic                                  external_monitor_use,
  output logic                                  merge_allowed,
  output logic                                  slave_port_error_response,
  output logic                                  slave_port_write_abort,
  output logic                                  debug_error_response,
  output logic                                  debug_prot_nonsecure
);
  import mem_policy_pkg::*;

  logic [`MP_CTRL_WIDTH-1:0]   ctrl_r;
  logic [`MP_ACTIVE_WIDTH-1:0] active_r;
  fault_class_type             class_r;
  fault_class_type             class_nxt;
  logic                        fault_valid_r;
  logic                        sync_r;
  logic                        sync_nxt;
  logic                        cpmiss_r;
  logic                        raz_r;
  logic                        wi_r;
  logic                        dalloc_r;
  logic                        ialloc_r;
  logic                        ualloc_r;
  logic                        uinval_r;
  logic                        bexcl_r;
  logic                        extmon_r;
  logic                        merge_r;
  logic                        sp_err_r;
  logic                        sp_abort_r;
  logic                        dbg_err_r;
  logic                        dbg_ns_r;
  logic [5:0]                  status_r;

  logic unalign_trap;
  logic dc_on;
  logic ic_on;
  logic dfault_en;
  logic sperr_en;
  logic apb_wr;
  logic usage_unaligned;
  logic usage_cpmiss;
  logic gate_data;
  logic bus_err;
  logic bus_fault;
  logic sync_case;
  logic cacheable;

  assign unalign_trap = ctrl_r[`MP_CTRL_UNALIGN_BIT];
  assign dc_on        = ctrl_r[`MP_CTRL_DC_BIT] & active_r[`MP_ACTIVE_DC_BIT];
  assign ic_on        = ctrl_r[`MP_CTRL_IC_BIT] & active_r[`MP_ACTIVE_IC_BIT];
  assign dfault_en    = ctrl_r[`MP_CTRL_DFAULT_BIT];
  assign sperr_en     = ctrl_r[`MP_CTRL_SPERR_BIT];
  assign apb_wr       = psel & penable & pwrite;

  // Register access: no wait states, unmapped addresses answer with an error.
  assign pready = 1'b1;

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (paddr == `MP_CTRL_OFFSET) begin
      prdata[`MP_CTRL_WIDTH-1:0] = ctrl_r;
    end else if (paddr == `MP_ACTIVE_OFFSET) begin
      prdata[`MP_ACTIVE_WIDTH-1:0] = active_r;
    end else if (paddr == `MP_STATUS_OFFSET) begin
      prdata[5:0] = status_r;
    end else begin
      pslverr = psel & penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= `MP_CTRL_RESET;
      active_r <= `MP_ACTIVE_RESET;
    end else if (apb_wr) begin
      if (paddr == `MP_CTRL_OFFSET) begin
        ctrl_r <= pwdata[`MP_CTRL_WIDTH-1:0];
      end else if (paddr == `MP_ACTIVE_OFFSET) begin
        active_r <= pwdata[`MP_ACTIVE_WIDTH-1:0];
      end
    end
  end

  // Fault sorting for the access presented in this cycle.
  always_comb begin
    usage_unaligned = (acc_unaligned & (unalign_trap | acc_no_unaligned_instr)) // [RL10]
                    | (acc_unaligned & acc_device & ~acc_fetch)                 // [RL11]
                    | (acc_vector & acc_elem_misaligned);                       // [RL12]
    usage_cpmiss    = coproc_access & ~coproc_present;                          // [RL13]
    // Data-side gate rejects fault only with data faults enabled.
    gate_data       = gate_reject & (acc_fetch | dfault_en);                    // [RL3]
    bus_err         = axi_slave_error | axi_decode_error                        // [RL1]
                    | (axi_read_poison & ~acc_store)                            // [RL1]
                    | periph_ahb_error                                          // [RL2]
                    | main_ahb_error | periph_apb_error | ecc_uncorrectable;
    bus_fault       = bus_err | gate_data | dirty_linefill_error
                    | (acc_store & acc_priv_periph & acc_priv_violation)
                    | ((acc_vector | acc_stacking) & acc_store & acc_priv_periph);
    sync_case       = acc_fetch | ~acc_store                                    // [RL6]
                    | gate_data                                                 // [RL6]
                    | (acc_priv_periph & acc_priv_violation)                    // [RL6]
                    | ((acc_vector | acc_stacking) & acc_priv_periph)           // [RL6]
                    | ecc_uncorrectable;                                        // [RL6]
    // Eviction ECC errors and dirty linefill errors are always late.
    if (dirty_linefill_error | (ecc_uncorrectable & ecc_in_eviction)) begin
      sync_case = 1'b0;                                                         // [RL7]
    end
    class_nxt = fault_none_type;
    sync_nxt  = 1'b0;
    // One class per access: protection, attribution, usage, then bus.
    if (protection_fault) begin
      class_nxt = fault_memmanage_type;                                         // [RL25]
      sync_nxt  = 1'b1;
    end else if (attribution_fault) begin
      class_nxt = fault_secure_type;                                            // [RL25]
      sync_nxt  = 1'b1;
    end else if (usage_unaligned | usage_cpmiss) begin
      class_nxt = fault_usage_type;                                             // [RL25]
      sync_nxt  = 1'b1;
    end else if (bus_fault) begin
      class_nxt = fault_bus_type;                                               // [RL25]
      sync_nxt  = sync_case;                                                    // [RL7]
    end
  end

  assign cacheable = acc_normal_cacheable & ~acc_device;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      class_r       <= fault_none_type;
      fault_valid_r <= 1'b0;
      sync_r        <= 1'b0;
      cpmiss_r      <= 1'b0;
      raz_r         <= 1'b0;
      wi_r          <= 1'b0;
    end else begin
      class_r       <= acc_valid ? class_nxt : fault_none_type;
      fault_valid_r <= acc_valid & (class_nxt != fault_none_type);
      sync_r        <= acc_valid & sync_nxt;
      cpmiss_r      <= acc_valid & usage_cpmiss & ~protection_fault & ~attribution_fault;
      raz_r         <= acc_valid & gate_reject & ~acc_fetch & ~acc_store & ~dfault_en; // [RL24]
      wi_r          <= acc_valid & gate_reject & ~acc_fetch & acc_store & ~dfault_en;  // [RL24]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dalloc_r <= 1'b0;
      ialloc_r <= 1'b0;
      ualloc_r <= 1'b0;
      uinval_r <= 1'b0;
    end else begin
      dalloc_r <= acc_valid & ~acc_fetch & cacheable & ~acc_shareable & dc_on; // [RL14] [RL15]
      ialloc_r <= acc_valid & acc_fetch & cacheable & ic_on;                   // [RL16]
      ualloc_r <= acc_valid & cacheable & acc_code_region & ~acc_store & dc_on // [RL17]
                & (acc_fetch | ~acc_shareable);                                // [RL17]
      uinval_r <= acc_valid & acc_store & acc_ucache_hit;                      // [RL18]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bexcl_r  <= 1'b0;
      extmon_r <= 1'b0;
      merge_r  <= 1'b0;
    end else begin
      bexcl_r  <= acc_valid & acc_exclusive & acc_shareable;                   // [RL19]
      extmon_r <= acc_valid & acc_exclusive & acc_shareable;                   // [RL20]
      merge_r  <= acc_valid & acc_merge_req & (~acc_device | acc_vector);      // [RL21] [RL23]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_err_r   <= 1'b0;
      sp_abort_r <= 1'b0;
    end else begin
      sp_err_r   <= slave_port_valid & slave_port_gate_reject & sperr_en;       // [RL4]
      sp_abort_r <= slave_port_valid & slave_port_write                         // [RL5]
                  & (instr_local_mem_error_in | data_local_mem_error_in);      // [RL5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_err_r <= 1'b0;
      dbg_ns_r  <= 1'b0;
    end else begin
      dbg_err_r <= debug_valid & debug_attr_blocked;                           // [RL8]
      dbg_ns_r  <= debug_valid ? debug_attr_nonsecure : dbg_ns_r;              // [RL9]
    end
  end

  // Status keeps the most recent fault or read-as-zero/write-ignore access until the next one replaces it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `MP_STATUS_RESET;
    end else if (fault_valid_r | raz_r | wi_r) begin
      status_r <= {raz_r | wi_r, cpmiss_r, sync_r, class_r};
    end
  end

  assign fault_class               = class_r;
  assign fault_valid               = fault_valid_r;
  assign fault_sync                = sync_r;
  assign fault_cpmiss              = cpmiss_r;
  assign read_as_zero              = raz_r;
  assign write_ignore              = wi_r;
  assign dcache_allocate           = dalloc_r;
  assign icache_allocate           = ialloc_r;
  assign ucache_allocate           = ualloc_r;
  assign ucache_invalidate         = uinval_r;
  assign bus_exclusive             = bexcl_r;
  assign external_monitor_use      = extmon_r;
  assign merge_allowed             = merge_r;
  assign slave_port_error_response = sp_err_r;
  assign slave_port_write_abort    = sp_abort_r;
  assign debug_error_response      = dbg_err_r;
  assign debug_prot_nonsecure      = dbg_ns_r;

  // Checks on the registered decisions.
  poison_fault_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
    (acc_valid & axi_read_poison & ~acc_store & ~protection_fault & ~attribution_fault
     & ~acc_unaligned & ~acc_elem_misaligned & ~coproc_access & ~dirty_linefill_error
     & ~ecc_in_eviction)
    |=> (fault_class == fault_bus_type) && fault_sync)
    else $error("poisoned read did not give a synchronous bus fault");

  periph_err_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
    (acc_valid & periph_ahb_error & ~protection_fault & ~attribution_fault
     & ~acc_unaligned & ~acc_elem_misaligned & ~coproc_access)
    |=> fault_valid && (fault_class == fault_bus_type))
    else $error("peripheral bus error not reported as bus fault");

  gate_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
    (acc_valid & gate_reject & dfault_en & acc_store & ~protection_fault & ~attribution_fault
     & ~acc_unaligned & ~acc_elem_misaligned & ~coproc_access & ~dirty_linefill_error
     & ~ecc_uncorrectable)
    |=> (fault_class == fault_bus_type) && fault_sync)
    else $error("gate rejected store was not a synchronous bus fault");

  sp_error_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
    slave_port_error_response |-> $past(slave_port_gate_reject) && $past(sperr_en))
    else $error("slave port error without gate reject");

  sp_abort_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
    slave_port_write_abort |-> $past(slave_port_write)
      && ($past(instr_local_mem_error_in) || $past(data_local_mem_error_in)))
    else $error("write abort without a local memory error");

  late_store_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
    (acc_valid & acc_store & ~acc_fetch & axi_slave_error & ~gate_reject & ~acc_priv_periph
     & ~ecc_uncorrectable & ~protection_fault & ~attribution_fault & ~acc_unaligned
     & ~acc_elem_misaligned & ~coproc_access)
    |=> fault_valid && !fault_sync)
    else $error("plain store bus error was not asynchronous");

  debug_block_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL8]
    (debug_valid & debug_attr_blocked & ~acc_valid)
    |=> debug_error_response && (fault_class != fault_secure_type))
    else $error("blocked debug access mishandled");

  trap_usage_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL10]
    (acc_valid & acc_unaligned & unalign_trap & ~protection_fault & ~attribution_fault)
    |=> fault_class == fault_usage_type)
    else $error("unaligned trap did not raise a usage fault");

  dshare_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL15]
    dcache_allocate |-> !$past(acc_shareable) && $past(dc_on))
    else $error("data allocation for shareable or disabled cache");

  excl_mark_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL19]
    (acc_valid & acc_exclusive) |=> (bus_exclusive == $past(acc_shareable)))
    else $error("exclusive marking does not follow shareability");

  device_merge_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL21]
    merge_allowed |-> (!$past(acc_device) || $past(acc_vector)))
    else $error("device accesses merged outside vector case");

  raz_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL24]
    (read_as_zero || write_ignore) |-> !fault_valid || $past(protection_fault)
      || $past(attribution_fault) || (fault_class != fault_bus_type))
    else $error("read-as-zero access also raised a bus fault");

  bus_late_cov: cover property (@(posedge pclk) disable iff (!presetn)
    fault_valid && (fault_class == fault_bus_type) && !fault_sync);
  cpmiss_cov: cover property (@(posedge pclk) disable iff (!presetn) fault_cpmiss);
  ialloc_cov: cover property (@(posedge pclk) disable iff (!presetn)
    icache_allocate ##1 ucache_invalidate);
  sp_abort_cov: cover property (@(posedge pclk) disable iff (!presetn) slave_port_write_abort);

endmodule

// [sim/interconnect_model.sv]
// Purpose: Far-side model of the interconnect and local memories for one access.
// Assumes: Error lines are levels in the cycle in which the access is presented.
// Notes:   Code 0 is a clean answer; codes 1 to 8 raise exactly one error line.
`timescale 1ns/100ps
module interconnect_model (
  input  wire logic [3:0] resp,
  output logic            axi_slave_error,
  output logic            axi_decode_error,
  output logic            axi_read_poison,
  output logic            main_ahb_error,
  output logic            periph_ahb_error,
  output logic            periph_apb_error,
  output logic            data_local_mem_error_in,
  output logic            instr_local_mem_error_in
);
  logic [8:0] hot;
  // Each access gets its own answer, so no two accesses are ever merged here.
  assign hot = 9'h001 << resp;
  assign {instr_local_mem_error_in, data_local_mem_error_in, periph_apb_error, periph_ahb_error,
          main_ahb_error, axi_read_poison, axi_decode_error, axi_slave_error} = hot[8:1];
endmodule

// [sim/memory_fault_and_attribute_policy_test.sv]
// Purpose: Self-checking bench for the memory fault and attribute policy unit.
// Assumes: Zero-wait APB slave; policy outputs one cycle after the access.
// Notes:   Access inputs travel in one word so that each drive is a single assignment.
`timescale 1ns/100ps
`include "mem_policy_params.svh"
module memory_fault_and_attribute_policy_test;
  import mem_policy_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [30:0] av = 31'h0;
  logic [3:0] resp = 4'h0;
  logic acc_valid, acc_fetch, acc_store, acc_vector, acc_stacking, acc_exclusive, acc_unaligned,
    acc_elem_misaligned, acc_no_unaligned_instr, acc_device, acc_normal_cacheable, acc_shareable,
    acc_code_region, acc_priv_periph, acc_priv_violation, acc_merge_req, acc_ucache_hit,
    gate_reject,
    protection_fault, attribution_fault, coproc_access, coproc_present, ecc_uncorrectable,
    ecc_in_eviction, dirty_linefill_error, slave_port_valid, slave_port_write,
    slave_port_gate_reject, debug_valid, debug_attr_blocked, debug_attr_nonsecure;
  logic axi_slave_error, axi_decode_error, axi_read_poison, main_ahb_error, periph_ahb_error,
    periph_apb_error, instr_local_mem_error_in, data_local_mem_error_in;
  fault_class_type fault_class;
  logic fault_valid, fault_sync, fault_cpmiss, read_as_zero, write_ignore, dcache_allocate,
    icache_allocate, ucache_allocate, ucache_invalidate, bus_exclusive, external_monitor_use,
    merge_allowed, slave_port_error_response, slave_port_write_abort, debug_error_response,
    debug_prot_nonsecure;
  logic [17:0] ov;
  int fails = 0, compares = 0;
  localparam logic [30:0] V = 31'h1, FE = 31'h2, ST = 31'h4, VEC = 31'h8, STK = 31'h10,
    EX = 31'h20, UN = 31'h40, EL = 31'h80, NU = 31'h100, DEV = 31'h200, NC = 31'h400,
    SH = 31'h800, CR = 31'h1000, PS = 31'h2000, PV = 31'h4000, MG = 31'h8000, UH = 31'h10000,
    GR = 31'h20000, PF = 31'h40000, AF = 31'h80000, CA = 31'h100000, CP = 31'h200000,
    ECC = 31'h400000, EV = 31'h800000, DL = 31'h1000000, SV = 31'h2000000, SW = 31'h4000000,
    SG = 31'h8000000, DV = 31'h10000000, DB = 31'h20000000, DN = 31'h40000000;
  localparam logic [11:0] CT = `MP_CTRL_OFFSET, AC = `MP_ACTIVE_OFFSET, STS = `MP_STATUS_OFFSET;
  localparam logic [17:0] BS = {fault_bus_type, 15'h6000}, BA = {fault_bus_type, 15'h4000},
    US = {fault_usage_type, 15'h6000}, SF = {fault_secure_type, 15'h6000},
    MF = {fault_memmanage_type, 15'h6000};
  assign {debug_attr_nonsecure, debug_attr_blocked, debug_valid, slave_port_gate_reject,
    slave_port_write, slave_port_valid, dirty_linefill_error, ecc_in_eviction, ecc_uncorrectable,
    coproc_present, coproc_access, attribution_fault, protection_fault, gate_reject,
    acc_ucache_hit, acc_merge_req, acc_priv_violation, acc_priv_periph, acc_code_region,
    acc_shareable,
    acc_normal_cacheable, acc_device, acc_no_unaligned_instr, acc_elem_misaligned, acc_unaligned,
    acc_exclusive, acc_stacking, acc_vector, acc_store, acc_fetch, acc_valid} = av;
  assign ov = {fault_class, fault_valid, fault_sync, fault_cpmiss, read_as_zero, write_ignore,
    dcache_allocate, icache_allocate, ucache_allocate, ucache_invalidate, bus_exclusive,
    external_monitor_use, merge_allowed, slave_port_error_response, slave_port_write_abort,
    debug_error_response};
  mem_policy i_dut (.*);
  interconnect_model i_bus (.*);
  always #25 pclk = ~pclk;
  task chk(input logic [32:0] seen, input logic [32:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  task print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk({pslverr, prdata}, e);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input logic [30:0] a, input logic [3:0] r, input logic [17:0] e);
    @(posedge pclk);
    av <= a;
    resp <= r;
    @(posedge pclk);
    av <= 31'h0;
    resp <= 4'h0;
    #1;
    chk(ov, e);
  endtask
  task t_regs;
    apb(1'b0, CT, 32'h0, 33'h0);
    apb(1'b0, AC, 32'h0, 33'h0);
    apb(1'b0, 12'h00c, 32'h0, 33'h100000000);
    apb(1'b1, CT, 32'hffffffff, 33'h0);
    apb(1'b0, CT, 32'h0, 33'h1f);
    apb(1'b1, STS, 32'hffffffff, 33'h0);
    apb(1'b0, STS, 32'h0, 33'h0);
    $display("register test done");
  endtask
  task t_bus;
    run(V, 4'h3, BS);
    apb(1'b0, STS, 32'h0, 33'h0a);
    run(V|FE, 4'h1, BS);
    run(V, 4'h2, BS);
    run(V, 4'h5, BS);
    run(V|ST, 4'h1, BA);
    run(V|ST, 4'h5, BA);
    run(V|ST|PS|PV, 4'h6, BS);
    run(V|ST|STK|PS, 4'h4, BS);
    run(V|ECC, 4'h0, BS);
    run(V|ECC|EV, 4'h0, BA);
    run(V|DL, 4'h1, BA);
    $display("bus fault test done");
  endtask
  task t_gate;
    apb(1'b1, CT, 32'h0, 33'h0);
    run(V|FE|GR, 4'h0, BS);
    run(V|GR, 4'h7, 18'h800);
    run(V|ST|GR, 4'h0, 18'h400);
    apb(1'b1, CT, 32'h18, 33'h0);
    run(V|ST|GR, 4'h0, BS);
    run(SV|SW|SG, 4'h0, 18'h4);
    run(SV|SW, 4'h7, 18'h2);
    run(SV|SW, 4'h8, 18'h2);
    run(SV|SW, 4'h1, 18'h0);
    $display("gate test done");
  endtask
  task t_usage;
    apb(1'b1, CT, 32'h1, 33'h0);
    run(V|UN, 4'h0, US);
    apb(1'b1, CT, 32'h0, 33'h0);
    run(V|UN, 4'h0, 18'h0);
    run(V|UN|NU, 4'h0, US);
    run(V|UN|DEV, 4'h1, US);
    run(V|VEC|EL, 4'h0, US);
    run(V|CA, 4'h0, US | 18'h1000);
    run(V|CA|CP, 4'h0, 18'h0);
    run(V|PF|AF, 4'h1, MF);
    run(V|AF, 4'h0, SF);
    $display("usage test done");
  endtask
  task t_cache;
    apb(1'b1, CT, 32'h6, 33'h0);
    run(V|NC, 4'h0, 18'h0);
    apb(1'b1, AC, 32'h3, 33'h0);
    run(V|NC, 4'h0, 18'h200);
    run(V|NC|SH, 4'h0, 18'h0);
    run(V|FE|NC|SH, 4'h0, 18'h100);
    run(V|FE, 4'h0, 18'h0);
    apb(1'b1, CT, 32'h2, 33'h0);
    run(V|FE|NC|SH|CR, 4'h0, 18'h80);
    run(V|NC|SH|CR, 4'h0, 18'h0);
    run(V|ST|NC|SH|CR|UH, 4'h0, 18'h40);
    $display("cache test done");
  endtask
  task t_attr;
    run(DV|DB|DN, 4'h0, 18'h1);
    chk(debug_prot_nonsecure, 1'b1);
    run(DV, 4'h0, 18'h0);
    chk(debug_prot_nonsecure, 1'b0);
    run(V|EX|SH, 4'h0, 18'h30);
    run(V|EX, 4'h0, 18'h0);
    run(V|MG|DEV, 4'h0, 18'h0);
    run(V|MG|DEV|VEC, 4'h0, 18'h8);
    $display("attribute test done");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_bus;
    t_gate;
    t_usage;
    t_cache;
    t_attr;
    print_verdict;
  end
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
endmodule
